// ---- rtl/fsil_latch.sv ----
`timescale 1ns/1ps
// ============================================================
// one latched status register with write mask and pending flags
module fsil_latch #(
  parameter logic [7:0] ALARM_BITS = 8'h00 // positions holding alarms
) (
  input  wire logic       clock,   // system clock
  input  wire logic       rst,     // synchronous reset
  input  wire logic       ce,      // clock enable
  input  wire logic [7:0] ev,      // event pulses
  input  wire logic [7:0] alarm,   // alarm levels
  input  wire logic       wr,      // mask write strobe
  input  wire logic       rd,      // read strobe
  input  wire logic [7:0] wdata,   // mask byte
  output logic      [7:0] held,    // readable value
  output logic      [7:0] pend     // interrupt pending flags
);

  typedef struct packed {
    logic [7:0] latched;
    logic [7:0] held;
    logic [7:0] mask;
    logic [7:0] alarm_q;
    logic [7:0] pend;
  } fsil_latch_s;

  fsil_latch_s s_r;
  fsil_latch_s s_nxt;
  logic [7:0]  evt;
  logic [7:0]  chg;
  logic [7:0]  clr;

  // next state: set wins over read clear
  always_comb begin
    s_nxt = s_r;
    evt   = ev & ~ALARM_BITS;
    chg   = ALARM_BITS & (alarm ^ s_r.alarm_q);
    clr   = rd ? s_r.mask : 8'h00;
    s_nxt.alarm_q = alarm & ALARM_BITS;
    s_nxt.latched = (s_r.latched & ~clr) | evt | chg | (alarm & ALARM_BITS);
    s_nxt.pend = (s_r.pend & ~clr) | evt | chg;
    if (wr) begin
      s_nxt.mask = wdata;
      s_nxt.held = (s_r.held & ~wdata) | (s_nxt.latched & wdata);
    end
  end

  // state register
  always_ff @(posedge clock) begin
    if (rst) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign held = s_r.held;
  assign pend = s_r.pend;

  // ============================================================
  // checks
  evt_kept_a : assert property (@(posedge clock) disable iff (rst)
    ce && rd && (evt != 8'h00) |=> ((s_r.latched & $past(evt)) == $past(evt)))
    else $error("event lost during read clear");
  alarm_held_a : assert property (@(posedge clock) disable iff (rst)
    ce && rd |=> ((s_r.latched & $past(alarm) & ALARM_BITS) == ($past(alarm) & ALARM_BITS)))
    else $error("present alarm cleared by read");
  mask_hold_a : assert property (@(posedge clock) disable iff (rst)
    ce && wr |=> ((s_r.held & ~$past(wdata)) == ($past(s_r.held) & ~$past(wdata))))
    else $error("unmasked position changed on write");
  read_clear_a : assert property (@(posedge clock) disable iff (rst)
    ce && rd && (evt == 8'h00) && (chg == 8'h00) |=> ((s_r.pend & $past(s_r.mask)) == 8'h00))
    else $error("read did not clear pending bit");

endmodule

// ---- rtl/fsil_pkg.sv ----
// ============================================================
// shared constants of the framer status and interrupt logic
package fsil_pkg;

  // ============================================================
  // register addresses on the parallel control port
  localparam logic [7:0] ADDR_STATUS_ONE    = 8'h06;
  localparam logic [7:0] ADDR_STATUS_TWO    = 8'h07;
  localparam logic [7:0] ADDR_RECEIVE_INFO  = 8'h08;
  localparam logic [7:0] ADDR_INT_MASK_ONE  = 8'h16;
  localparam logic [7:0] ADDR_INT_MASK_TWO  = 8'h17;
  localparam logic [7:0] ADDR_COMMON_CTRL_6 = 8'h1d;
  localparam logic [7:0] ADDR_SYNC_STATE    = 8'h1e;

  // ============================================================
  // common_control_six field positions
  localparam int CC6_TX_CLK_SRC  = 2;
  localparam int CC6_RX_ES_RESET = 1;
  localparam int CC6_TX_ES_RESET = 0;
  localparam logic [7:0] CC6_WRITABLE = 8'he7; // bits 4 and 3 unassigned

  // ============================================================
  // reset values
  localparam logic [7:0] CC6_RESET      = 8'h00;
  localparam logic [7:0] INT_MASK_RESET = 8'h00; // all sources masked
  localparam logic [7:0] STATUS_RESET   = 8'h00;

  // ============================================================
  // alarm positions of the latched registers (others are events)
  localparam logic [7:0] ALARMS_STATUS_ONE = 8'h0f;
  localparam logic [7:0] ALARMS_NONE       = 8'h00;
  localparam int         NUM_LATCHED       = 3;

endpackage

// ---- rtl/fsil_top.sv ----
`timescale 1ns/1ps
module fsil_top (
  input  wire logic       clock,                     // 100 mhz system clock
  input  wire logic       rst,                       // synchronous reset
  input  wire logic       ce,                        // clock enable
  input  wire logic [7:0] cpu_addr,                  // register address
  input  wire logic       cpu_wr,                    // write strobe, one cycle
  input  wire logic       cpu_rd,                    // read strobe, one cycle
  input  wire logic [7:0] cpu_wdata,                 // write data
  output logic      [7:0] cpu_rdata,                 // read data
  input  wire logic [7:4] status_one_events,         // sr1 event pulses
  input  wire logic       unframed_all_ones_alarm,   // alarm level
  input  wire logic       remote_alarm,              // alarm level
  input  wire logic       carrier_loss_alarm,        // alarm level
  input  wire logic       loss_of_sync_alarm,        // alarm level
  input  wire logic [7:0] status_two_events,         // sr2 event pulses
  input  wire logic [7:0] receive_info_events,       // rir event pulses
  input  wire logic [7:0] synchronizer_state,        // live synchronizer state
  input  wire logic       hdlc_int_req,              // hdlc pending unmasked
  input  wire logic       lost_tx_clock_mux_control, // from common_control_two
  input  wire logic       lost_tx_clock,             // transmit clock lost
  output logic            int_n,                     // interrupt, active low
  output logic            tx_clk_from_rx,            // formatter uses rx clock
  output logic            rx_elastic_reset,          // one-cycle store reset
  output logic            tx_elastic_reset,          // one-cycle store reset
  output logic      [7:0] common_control_six         // control register copy
);

  // ============================================================
  // state
  typedef struct packed {
    logic [7:0] cc6;
    logic [7:0] interrupt_mask_one;
    logic [7:0] interrupt_mask_two;
    logic [7:0] rdata;
    logic       int_n;
    logic       tx_from_rx;
    logic       rx_rst;
    logic       tx_rst;
  } fsil_state_s;

  fsil_state_s s_r;
  fsil_state_s s_nxt;

  logic [7:0] held [fsil_pkg::NUM_LATCHED];
  logic [7:0] pend [fsil_pkg::NUM_LATCHED];
  logic [7:0] evs  [fsil_pkg::NUM_LATCHED];
  logic [7:0] alms [fsil_pkg::NUM_LATCHED];
  logic [7:0] laddr[fsil_pkg::NUM_LATCHED];

  // address match, used by the latch strobes and the register writes
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // ============================================================
  // latched status registers
  assign evs[0]   = {status_one_events, 4'h0};
  assign alms[0]  = {4'h0, unframed_all_ones_alarm, remote_alarm, carrier_loss_alarm, loss_of_sync_alarm};
  assign evs[1]   = status_two_events;
  assign alms[1]  = 8'h00;
  assign evs[2]   = receive_info_events;
  assign alms[2]  = 8'h00;
  assign laddr[0] = fsil_pkg::ADDR_STATUS_ONE;
  assign laddr[1] = fsil_pkg::ADDR_STATUS_TWO;
  assign laddr[2] = fsil_pkg::ADDR_RECEIVE_INFO;

  // one latch per status register
  for (genvar g = 0; g < fsil_pkg::NUM_LATCHED; g++) begin : g_latch
    fsil_latch #(
      .ALARM_BITS((g == 0) ? fsil_pkg::ALARMS_STATUS_ONE : fsil_pkg::ALARMS_NONE)
    ) u_latch (
      .clock (clock),
      .rst   (rst),
      .ce    (ce),
      .ev    (evs[g]),
      .alarm (alms[g]),
      .wr    (cpu_wr && hit(cpu_addr, laddr[g])),
      .rd    (cpu_rd && hit(cpu_addr, laddr[g])),
      .wdata (cpu_wdata),
      .held  (held[g]),
      .pend  (pend[g])
    );
  end

  // ============================================================
  // next state
  always_comb begin
    s_nxt        = s_r;
    s_nxt.rx_rst = 1'b0;
    s_nxt.tx_rst = 1'b0;
    if (cpu_wr) begin
      if (hit(cpu_addr, fsil_pkg::ADDR_COMMON_CTRL_6)) begin
        s_nxt.cc6 = cpu_wdata & fsil_pkg::CC6_WRITABLE;
        s_nxt.rx_rst = cpu_wdata[fsil_pkg::CC6_RX_ES_RESET] & ~s_r.cc6[fsil_pkg::CC6_RX_ES_RESET];
        s_nxt.tx_rst = cpu_wdata[fsil_pkg::CC6_TX_ES_RESET] & ~s_r.cc6[fsil_pkg::CC6_TX_ES_RESET];
      end
      if (hit(cpu_addr, fsil_pkg::ADDR_INT_MASK_ONE)) begin
        s_nxt.interrupt_mask_one = cpu_wdata;
      end
      if (hit(cpu_addr, fsil_pkg::ADDR_INT_MASK_TWO)) begin
        s_nxt.interrupt_mask_two = cpu_wdata;
      end
    end
    // read mux, unmapped reads as zero
    if (cpu_rd) begin
      case (cpu_addr)
        fsil_pkg::ADDR_STATUS_ONE:    s_nxt.rdata = held[0];
        fsil_pkg::ADDR_STATUS_TWO:    s_nxt.rdata = held[1];
        fsil_pkg::ADDR_RECEIVE_INFO:  s_nxt.rdata = held[2];
        fsil_pkg::ADDR_INT_MASK_ONE:  s_nxt.rdata = s_r.interrupt_mask_one;
        fsil_pkg::ADDR_INT_MASK_TWO:  s_nxt.rdata = s_r.interrupt_mask_two;
        fsil_pkg::ADDR_COMMON_CTRL_6: s_nxt.rdata = s_r.cc6;
        fsil_pkg::ADDR_SYNC_STATE:    s_nxt.rdata = synchronizer_state;
        default:                      s_nxt.rdata = 8'h00;
      endcase
    end
    s_nxt.tx_from_rx = s_r.cc6[fsil_pkg::CC6_TX_CLK_SRC] | (lost_tx_clock_mux_control & lost_tx_clock);
    s_nxt.int_n = ~((|(pend[0] & s_r.interrupt_mask_one)) | (|(pend[1] & s_r.interrupt_mask_two)) | hdlc_int_req);
  end

  // state register
  always_ff @(posedge clock) begin
    if (rst) begin
      s_r.cc6        <= fsil_pkg::CC6_RESET;
      s_r.interrupt_mask_one       <= fsil_pkg::INT_MASK_RESET;
      s_r.interrupt_mask_two       <= fsil_pkg::INT_MASK_RESET;
      s_r.rdata      <= fsil_pkg::STATUS_RESET;
      s_r.int_n      <= 1'b1;
      s_r.tx_from_rx <= 1'b0;
      s_r.rx_rst     <= 1'b0;
      s_r.tx_rst     <= 1'b0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from flip-flops
  assign cpu_rdata          = s_r.rdata;
  assign int_n              = s_r.int_n;
  assign tx_clk_from_rx     = s_r.tx_from_rx;
  assign rx_elastic_reset   = s_r.rx_rst;
  assign tx_elastic_reset   = s_r.tx_rst;
  assign common_control_six = s_r.cc6;

  // ============================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // alarm levels seen by the checks
  logic [3:0] alarm_now;
  assign alarm_now = {unframed_all_ones_alarm, remote_alarm, carrier_loss_alarm, loss_of_sync_alarm};

  rx_reset_edge_a : assert property (
    ce && cpu_wr && hit(cpu_addr, fsil_pkg::ADDR_COMMON_CTRL_6) && cpu_wdata[1] && !s_r.cc6[1]
    |=> rx_elastic_reset ##1 (!rx_elastic_reset || !$past(ce)))
    else $error("receive store reset not a single pulse");
  rx_reset_level_a : assert property (
    ce && s_r.cc6[fsil_pkg::CC6_RX_ES_RESET] |=> !rx_elastic_reset)
    else $error("receive store reset without rising edge");
  tx_reset_edge_a : assert property (
    ce && cpu_wr && hit(cpu_addr, fsil_pkg::ADDR_COMMON_CTRL_6) && cpu_wdata[fsil_pkg::CC6_TX_ES_RESET]
    && !s_r.cc6[fsil_pkg::CC6_TX_ES_RESET] |=> tx_elastic_reset)
    else $error("transmit store reset missing on rising bit");
  tx_reset_level_a : assert property (
    ce && s_r.cc6[0] |=> !tx_elastic_reset)
    else $error("transmit store reset without rising edge");
  tx_clk_forced_a : assert property (
    ce && s_r.cc6[2] && $past(ce) && $past(s_r.cc6[2]) |-> tx_clk_from_rx)
    else $error("transmit clock not forced to receive clock");
  tx_clk_lost_tx_clock_event_a : assert property (
    ce && !s_r.cc6[2] |=> (tx_clk_from_rx == $past(lost_tx_clock_mux_control & lost_tx_clock)))
    else $error("transmit clock select ignores mux control");
  sync_live_a : assert property (
    ce && cpu_rd && hit(cpu_addr, fsil_pkg::ADDR_SYNC_STATE) |=> (cpu_rdata == $past(synchronizer_state)))
    else $error("synchronizer state not read live");
  int_level_a : assert property (
    ce |=> (int_n == !($past(|(pend[0] & s_r.interrupt_mask_one)) || $past(|(pend[1] & s_r.interrupt_mask_two)) || $past(hdlc_int_req))))
    else $error("interrupt output does not follow pending sources");
  event_int_a : assert property (
    ce && !cpu_wr && |(status_two_events & s_r.interrupt_mask_two) ##1 ce |=> !int_n)
    else $error("unmasked event did not interrupt");
  alarm_int_a : assert property (
    ce && $past(ce) && !$past(rst) && !cpu_wr
    && |(s_r.interrupt_mask_one[3:0] & (alarm_now ^ $past(alarm_now))) ##1 ce |=> !int_n)
    else $error("unmasked alarm change did not interrupt");

  // main scenarios reached
  alarm_int_c  : cover property (ce && !int_n && (pend[0][3:0] != 4'h0));
  event_int_c  : cover property (ce && !int_n ##[1:20] int_n);
  es_reset_c   : cover property (rx_elastic_reset ##[1:50] tx_elastic_reset);
  ce_freeze_c  : cover property (!ce && cpu_wr);
  mask_write_c : cover property (cpu_wr && hit(cpu_addr, fsil_pkg::ADDR_STATUS_ONE) ##1 cpu_rd);

endmodule

// ---- tb/fsil_host.sv ----
`timescale 1ns/1ps
// ============================================================
// host model on the parallel control port
module fsil_host (
  input  wire logic       clock,     // system clock
  output logic      [7:0] cpu_addr,  // register address
  output logic            cpu_wr,    // write strobe
  output logic            cpu_rd,    // read strobe
  output logic      [7:0] cpu_wdata, // write data
  input  wire logic [7:0] cpu_rdata  // read data
);
  // idle bus at time zero
  initial begin
    cpu_addr = 8'h00;
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    cpu_wdata = 8'h00;
  end
  // one-cycle write pulse
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_wr <= 1'b1;
    @(posedge clock);
    cpu_wr <= 1'b0;
  endtask
  // one-cycle read pulse, data taken a cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    cpu_addr <= a;
    cpu_rd <= 1'b1;
    @(posedge clock);
    cpu_rd <= 1'b0;
    @(posedge clock);
    d = cpu_rdata;
  endtask
  task automatic poll(input logic [7:0] a, input logic [7:0] m, output logic [7:0] d);
    wr(a, m);
    rd(a, d);
    wr(a, d & m);
  endtask
  // toggles after clocks stable, spare bits zero
  task automatic ctl_wr(input logic [7:0] d);
    wr(fsil_pkg::ADDR_COMMON_CTRL_6, d & fsil_pkg::CC6_WRITABLE);
  endtask
endmodule

// ---- tb/fsil_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin miscompares++; \
  $display("FAIL %s exp %h got %h", nm, ex, got); end end
// ============================================================
// bench for the status and interrupt logic
module fsil_tb_top;
  logic       clock, rst, cpu_wr, cpu_rd, int_n, clk_rx, rx_rst, tx_rst, alarm, hdlc, mux, lost;
  logic       ce, ua_alarm, cl_alarm, ls_alarm;
  logic [7:0] addr, wdata, rdata, ev2, receive_information, sync, cc6, v;
  logic [3:0] ev1;
  int         miscompares, num_checks, rx_pulses, tx_pulses;

  fsil_top fsil_top_i (.clock(clock), .rst(rst), .ce(ce), .cpu_addr(addr), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_wdata(wdata), .cpu_rdata(rdata), .status_one_events(ev1),
    .unframed_all_ones_alarm(ua_alarm), .remote_alarm(alarm), .carrier_loss_alarm(cl_alarm),
    .loss_of_sync_alarm(ls_alarm), .status_two_events(ev2), .receive_info_events(receive_information),
    .synchronizer_state(sync), .hdlc_int_req(hdlc), .lost_tx_clock_mux_control(mux),
    .lost_tx_clock(lost), .int_n(int_n), .tx_clk_from_rx(clk_rx), .rx_elastic_reset(rx_rst),
    .tx_elastic_reset(tx_rst), .common_control_six(cc6));
  fsil_host fsil_host_i (.clock(clock), .cpu_addr(addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
    .cpu_wdata(wdata), .cpu_rdata(rdata));

  // clock and store reset pulse counters
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (rx_rst === 1'b1) rx_pulses++;
    if (tx_rst === 1'b1) tx_pulses++;
  end
  // counts and verdict
  task automatic end_sim();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // hang guard
  initial begin
    #50000;
    miscompares++;
    end_sim();
  end
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // one-cycle event pulses
  task automatic fire(input logic [3:0] a, input logic [7:0] b, input logic [7:0] c);
    @(posedge clock);
    ev1 <= a;
    ev2 <= b;
    receive_information <= c;
    @(posedge clock);
    ev1 <= 4'h0;
    ev2 <= 8'h00;
    receive_information <= 8'h00;
  endtask
  // ============================================================
  // main sequence
  initial begin
    rst = 1'b1; ev1 = 4'h0; ev2 = 8'h00; receive_information = 8'h00; sync = 8'h5a;
    alarm = 1'b0; hdlc = 1'b0; mux = 1'b0; lost = 1'b0;
    ce = 1'b1;
    ua_alarm = 1'b0;
    cl_alarm = 1'b0;
    ls_alarm = 1'b0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    fsil_host_i.rd(8'h1d, v);
    `CHK("cc6 reset", 8'h00, v)
    `CHK("int_n reset", 1'b1, int_n)
    fsil_host_i.ctl_wr(8'hfc);
    settle(2);
    `CHK("cc6 copy", 8'he4, cc6)
    `CHK("clk src one", 1'b1, clk_rx)
    @(posedge clock);
    mux <= 1'b1;
    lost <= 1'b1;
    fsil_host_i.ctl_wr(8'h00);
    settle(2);
    `CHK("clk src mux", 1'b1, clk_rx)
    @(posedge clock);
    lost <= 1'b0;
    settle(2);
    `CHK("clk src tx", 1'b0, clk_rx)
    fsil_host_i.ctl_wr(8'h03);
    fsil_host_i.ctl_wr(8'h03);
    fsil_host_i.ctl_wr(8'h00);
    fsil_host_i.ctl_wr(8'h02);
    settle(2);
    `CHK("rx store resets", 2, rx_pulses)
    `CHK("tx store resets", 1, tx_pulses)
    fsil_host_i.wr(8'h17, 8'hff);
    fire(4'h0, 8'h08, 8'h00);
    settle(2);
    `CHK("event int", 1'b0, int_n)
    fsil_host_i.poll(8'h07, 8'h08, v);
    `CHK("event latched", 8'h08, v)
    settle(3);
    `CHK("event release", 1'b1, int_n)
    fsil_host_i.poll(8'h07, 8'h08, v);
    `CHK("event cleared", 8'h00, v)
    fire(4'h0, 8'h01, 8'h00);
    fsil_host_i.poll(8'h07, 8'h08, v);
    `CHK("mask zero holds", 8'h00, v)
    fsil_host_i.poll(8'h07, 8'h01, v);
    `CHK("mask one updates", 8'h01, v)
    fsil_host_i.wr(8'h17, 8'h00);
    fire(4'h0, 8'h10, 8'h00);
    settle(3);
    `CHK("masked event", 1'b1, int_n)
    fsil_host_i.poll(8'h07, 8'h10, v);
    `CHK("masked latched", 8'h10, v)
    @(posedge clock);
    hdlc <= 1'b1;
    settle(3);
    `CHK("hdlc int", 1'b0, int_n)
    @(posedge clock);
    hdlc <= 1'b0;
    fsil_host_i.wr(8'h16, 8'hff);
    @(posedge clock);
    alarm <= 1'b1;
    settle(3);
    `CHK("alarm on int", 1'b0, int_n)
    fsil_host_i.poll(8'h06, 8'h04, v);
    `CHK("alarm latched", 8'h04, v)
    settle(3);
    `CHK("alarm release", 1'b1, int_n)
    fsil_host_i.poll(8'h06, 8'h04, v);
    `CHK("alarm stays", 8'h04, v)
    @(posedge clock);
    alarm <= 1'b0;
    settle(3);
    `CHK("alarm off int", 1'b0, int_n)
    fsil_host_i.poll(8'h06, 8'h04, v);
    fsil_host_i.poll(8'h06, 8'h04, v);
    `CHK("alarm cleared", 8'h00, v)
    // remaining three alarms on and off
    @(posedge clock);
    ua_alarm <= 1'b1;
    cl_alarm <= 1'b1;
    ls_alarm <= 1'b1;
    settle(3);
    `CHK("three alarms int", 1'b0, int_n)
    fsil_host_i.poll(8'h06, 8'h0b, v);
    `CHK("three alarms", 8'h0b, v)
    @(posedge clock);
    ua_alarm <= 1'b0;
    cl_alarm <= 1'b0;
    ls_alarm <= 1'b0;
    fsil_host_i.poll(8'h06, 8'h0b, v);
    fsil_host_i.poll(8'h06, 8'h0b, v);
    `CHK("three alarms clear", 8'h00, v)
    fire(4'h8, 8'h00, 8'h20);
    settle(2);
    `CHK("sr1 event int", 1'b0, int_n)
    fsil_host_i.poll(8'h06, 8'h80, v);
    `CHK("sr1 event", 8'h80, v)
    fsil_host_i.poll(8'h08, 8'h20, v);
    `CHK("info latched", 8'h20, v)
    // clock enable low freezes mask and drops events
    @(posedge clock);
    ce <= 1'b0;
    fsil_host_i.wr(8'h16, 8'h00);
    fire(4'h4, 8'h00, 8'h00);
    @(posedge clock);
    ce <= 1'b1;
    fsil_host_i.rd(8'h16, v);
    `CHK("ce freeze mask", 8'hff, v)
    `CHK("ce freeze int", 1'b1, int_n)
    fsil_host_i.poll(8'h06, 8'h40, v);
    `CHK("ce freeze event", 8'h00, v)
    fsil_host_i.rd(8'h1e, v);
    `CHK("sync live", 8'h5a, v)
    @(posedge clock);
    sync <= 8'ha5;
    fsil_host_i.rd(8'h1e, v);
    `CHK("sync follows", 8'ha5, v)
    fsil_host_i.rd(8'h40, v);
    `CHK("unmapped read", 8'h00, v)
    end_sim();
  end
endmodule
